// [rtl/vlan_defs.vh]
// constants for the vlan tag classify and edit datapath
`ifndef VLAN_DEFS_VH
`define VLAN_DEFS_VH
`define NPORT 8
`define PORT_W 3
`define VID_W 12
`define VID_DEFAULT 12'h001
`define VID_NULL 12'h000
`define VID_RSVD 12'hfff
`define TPID_HI 8'h81
`define TPID_LO 8'h00
`define TCI_CFI 1'h0
`define HDR_LAST 5'h0f
`define SA_END 5'h0c
`define TAG_BYTES 5'h04
`define EMIT_PASS 5'h10
`define EMIT_INS 5'h14
`define EMIT_STRIP 5'h0c
`define FCS_LAST 5'h03
`define ENT_W 16
`define ENT_UNT_LSB 8
`define TBL_AW 12
`define TBL_DEPTH 4096
`define TBL_LAST 12'hfff
`define CRC_INIT 32'hffffffff
`define CRC_POLY 32'hedb88320
`define BUF_W 9
`endif

// [rtl/vlan_table_ram.v]
// vlan membership table: one write port, one registered read port
`timescale 1ns/100ps
`include "vlan_defs.vh"
module vlan_table_ram (
   // clock and reset
   input wire ref_clk,
   input wire rst_b,
   // write port
   input wire wr_en,
   input wire [`TBL_AW-1:0] wr_addr,
   input wire [`ENT_W-1:0] wr_data,
   // read port
   input wire [`TBL_AW-1:0] rd_addr,
   output wire [`ENT_W-1:0] rd_data
);
   reg [`ENT_W-1:0] mem [0:`TBL_DEPTH-1];
   reg [`ENT_W-1:0] rd_ff;

   always @(posedge ref_clk)
   begin
      if (wr_en)
      begin
         mem[wr_addr] <= wr_data;
      end
   end

   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rd_ff <= {`ENT_W{1'b0}};
      end
      else
      begin
         rd_ff <= mem[rd_addr];
      end
   end

   assign rd_data = rd_ff;
endmodule // vlan_table_ram

// [rtl/byte_skid_buf.v]
// two-entry buffer between the editor and the egress stream
`timescale 1ns/100ps
`include "vlan_defs.vh"
module byte_skid_buf (
   // clock and reset
   input wire ref_clk,
   input wire rst_b,
   // fill side
   input wire push,
   input wire [`BUF_W-1:0] push_data,
   output wire push_ready,
   output wire [1:0] cnt_nxt,
   // drain side
   output wire out_valid,
   output wire [`BUF_W-1:0] out_data,
   input wire out_ready
);
   reg out_v_ff;
   reg sk_v_ff;
   reg [`BUF_W-1:0] out_d_ff;
   reg [`BUF_W-1:0] sk_d_ff;
   wire pop;
   wire out_free;

   assign pop = out_v_ff & out_ready;
   assign out_free = pop | ~out_v_ff;
   // a push is legal while a slot is free or one leaves this cycle
   assign push_ready = ~(out_v_ff & sk_v_ff) | pop;
   assign cnt_nxt = {1'b0, out_v_ff} + {1'b0, sk_v_ff} + {1'b0, push} - {1'b0, pop};

   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         out_v_ff <= 1'b0;
         sk_v_ff <= 1'b0;
         out_d_ff <= {`BUF_W{1'b0}};
         sk_d_ff <= {`BUF_W{1'b0}};
      end
      else if (out_free)
      begin
         if (sk_v_ff)
         begin
            out_v_ff <= 1'b1;
            out_d_ff <= sk_d_ff;
            sk_v_ff <= push;
            sk_d_ff <= push_data;
         end
         else
         begin
            out_v_ff <= push;
            out_d_ff <= push_data;
         end
      end
      else if (push)
      begin
         sk_v_ff <= 1'b1;
         sk_d_ff <= push_data;
      end
   end

   assign out_valid = out_v_ff;
   assign out_data = out_d_ff;
endmodule // byte_skid_buf

// [rtl/vlan_tag_classify_edit.v]
// ingress vlan classification and egress tag insert/strip with fcs regeneration
`timescale 1ns/100ps
`include "vlan_defs.vh"
// Operation
// - frame is tagged exactly when the ethertype after the source address is 8100
// - tag control is priority(3), cfi(1), vid(12), priority most significant
// - inserted tag goes right after the source address, before original ethertype
// - insertion adds exactly four octets, original octets kept unchanged in order
// - fcs is recomputed over the frame after a tag is inserted
// - untagged frames take the receiving port default vid for forwarding
// - tagged frames forward on their own vid, port default ignored
// - with no vlans configured every port is in vlan 1, default vid 1
// - frame dropped at egress port that is not in the frame's vlan
// - one default vid per port, membership in any number of table vlans
// - flooded frames only reach member ports of their vlan
// - tagged egress port inserts a tag with frame vid and priority
// - tagged egress port sends an already tagged frame with tag unchanged
// - untagged egress port strips the tag from every tagged frame
// - untagged egress port sends an untagged frame unchanged
// - after reset every port is an untagged member of vlan 1
// - joining a new vlan removes the port from vlan 1 members
// - vid is twelve bits, vids 1 to 4094 classified and looked up
module vlan_tag_classify_edit (
   // clock and reset
   input wire ref_clk,
   input wire rst_b,
   // ingress stream, fcs already removed
   input wire in_valid,
   input wire [7:0] in_data,
   input wire in_last,
   input wire [`PORT_W-1:0] in_port,
   input wire [`PORT_W-1:0] in_egr,
   input wire [2:0] in_pri,
   output wire in_ready,
   // egress stream, fcs appended
   output wire tx_valid,
   output wire [7:0] tx_data,
   output wire tx_last,
   input wire tx_ready,
   // vlan configuration
   input wire cfg_vlan_we,
   input wire [`VID_W-1:0] cfg_vlan_vid,
   input wire [`NPORT-1:0] cfg_vlan_member,
   input wire [`NPORT-1:0] cfg_vlan_untag,
   input wire cfg_pvid_we,
   input wire [`PORT_W-1:0] cfg_pvid_port,
   input wire [`VID_W-1:0] cfg_pvid_vid,
   output wire cfg_ready,
   // classification status
   output wire cls_valid,
   output wire [`VID_W-1:0] cls_vid,
   output wire cls_tagged,
   output wire drop
);
   localparam S_INIT = 3'd0;
   localparam S_HDR = 3'd1;
   localparam S_LOOK = 3'd2;
   localparam S_DEC = 3'd3;
   localparam S_EMIT = 3'd4;
   localparam S_BODY = 3'd5;
   localparam S_FCS = 3'd6;
   localparam S_DROP = 3'd7;
   localparam M_PASS = 2'd0;
   localparam M_INS = 2'd1;
   localparam M_STRIP = 2'd2;

   reg [2:0] state_ff;
   reg [2:0] nxt_state;
   reg [4:0] cnt_ff;
   reg [4:0] nxt_cnt;
   reg [127:0] hdr_ff;
   reg [`PORT_W-1:0] port_ff;
   reg [`PORT_W-1:0] egr_ff;
   reg [2:0] pri_ff;
   reg [`VID_W-1:0] vid_ff;
   reg tagged_ff;
   reg last_seen_ff;
   reg [1:0] mode_ff;
   reg [1:0] nxt_mode;
   reg [31:0] crc_ff;
   reg [`TBL_AW-1:0] init_addr_ff;
   reg in_ready_ff;
   reg cfg_ready_ff;
   reg cls_valid_ff;
   reg [`VID_W-1:0] cls_vid_ff;
   reg cls_tagged_ff;
   reg drop_ff;
   reg nxt_drop;
   reg [`NPORT-1:0] v1_member_ff;
   reg [`NPORT-1:0] v1_untag_ff;
   reg buf_push;
   reg [7:0] buf_byte;
   reg buf_last;
   reg [4:0] emit_len;
   reg [7:0] emit_byte;
   wire buf_ready;
   wire [1:0] buf_cnt_nxt;
   wire [`BUF_W-1:0] tx_word;
   wire [`NPORT*`VID_W-1:0] pvid_flat;
   wire [`VID_W-1:0] pvid_sel;
   wire tag_seen;
   wire [15:0] tci;
   wire [`VID_W-1:0] look_vid;
   wire [`ENT_W-1:0] tbl_rd;
   wire [`ENT_W-1:0] entry;
   wire is_member;
   wire is_untag;
   wire bad_vid;
   wire hdr_take;
   wire body_take;
   wire tbl_we;
   wire [`TBL_AW-1:0] tbl_wa;
   wire [`ENT_W-1:0] tbl_wd;
   wire [31:0] fcs;
   wire [15:0] ins_tci;

   // header byte idx counted from the destination address
   function [7:0] hbyte;
      input [127:0] h;
      input [4:0] i;
      reg [127:0] s;
      begin
         s = h << {i[3:0], 3'b000};
         hbyte = s[127:120];
      end
   endfunction

   // reflected ethernet crc, one byte lsb first
   function [31:0] crc_step;
      input [31:0] c;
      input [7:0] d;
      integer k;
      reg [31:0] r;
      begin
         r = c;
         for (k = 0; k < 8; k = k + 1)
         begin
            if (r[0] ^ d[k])
               r = (r >> 1) ^ `CRC_POLY;
            else
               r = r >> 1;
         end
         crc_step = r;
      end
   endfunction

   // per-port default vid, one register per port
   genvar g;
   generate
      for (g = 0; g < `NPORT; g = g + 1)
      begin : gen_pvid
         reg [`VID_W-1:0] pv_ff;
         always @(posedge ref_clk or negedge rst_b)
         begin
            if (!rst_b)
               pv_ff <= `VID_DEFAULT;
            else if (cfg_pvid_we && cfg_pvid_port == g)
               pv_ff <= cfg_pvid_vid;
         end
         assign pvid_flat[g*`VID_W +: `VID_W] = pv_ff;
      end
   endgenerate

   assign pvid_sel = pvid_flat[port_ff*`VID_W +: `VID_W];
   assign tag_seen = (hbyte(hdr_ff, `SA_END) == `TPID_HI) &&
                     (hbyte(hdr_ff, `SA_END + 5'd1) == `TPID_LO);
   assign tci = {hbyte(hdr_ff, `SA_END + 5'd2), hbyte(hdr_ff, `SA_END + 5'd3)};
   assign look_vid = tag_seen ? tci[`VID_W-1:0] : pvid_sel;
   // vlan 1 lives in flops so it is valid straight out of reset
   assign entry = (vid_ff == `VID_DEFAULT) ? {v1_untag_ff, v1_member_ff} : tbl_rd;
   assign is_member = entry[egr_ff];
   assign is_untag = entry[`ENT_UNT_LSB + egr_ff];
   assign bad_vid = (vid_ff == `VID_NULL) || (vid_ff == `VID_RSVD);
   assign ins_tci = {pri_ff, `TCI_CFI, vid_ff};
   assign fcs = ~crc_ff;
   assign hdr_take = (state_ff == S_HDR) && in_valid && in_ready_ff;
   assign body_take = (state_ff == S_BODY) && in_valid && in_ready_ff;

   // table sweep clears stale entries, so unknown vids have no members
   assign tbl_we = (state_ff == S_INIT) || (cfg_vlan_we && cfg_vlan_vid != `VID_DEFAULT);
   assign tbl_wa = (state_ff == S_INIT) ? init_addr_ff : cfg_vlan_vid;
   assign tbl_wd = (state_ff == S_INIT) ? {`ENT_W{1'b0}} :
                   {cfg_vlan_untag & cfg_vlan_member, cfg_vlan_member};

   vlan_table_ram u_table (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .wr_en(tbl_we),
      .wr_addr(tbl_wa),
      .wr_data(tbl_wd),
      .rd_addr(look_vid),
      .rd_data(tbl_rd)
   );

   // emitted header byte for each edit mode
   always @*
   begin
      emit_len = `EMIT_PASS;
      emit_byte = hbyte(hdr_ff, cnt_ff);
      case (mode_ff)
         M_INS:
         begin
            emit_len = `EMIT_INS;
            if (cnt_ff == `SA_END)
               emit_byte = `TPID_HI;
            else if (cnt_ff == `SA_END + 5'd1)
               emit_byte = `TPID_LO;
            else if (cnt_ff == `SA_END + 5'd2)
               emit_byte = ins_tci[15:8];
            else if (cnt_ff == `SA_END + 5'd3)
               emit_byte = ins_tci[7:0];
            else if (cnt_ff > `SA_END + 5'd3)
               emit_byte = hbyte(hdr_ff, cnt_ff - `TAG_BYTES);
         end
         M_STRIP:
            emit_len = `EMIT_STRIP;
         default:
            emit_len = `EMIT_PASS;
      endcase
   end

   always @*
   begin
      nxt_state = state_ff;
      nxt_cnt = cnt_ff;
      nxt_mode = mode_ff;
      nxt_drop = 1'b0;
      buf_push = 1'b0;
      buf_byte = in_data;
      buf_last = 1'b0;
      case (state_ff)
         S_INIT:
         begin
            if (init_addr_ff == `TBL_LAST)
               nxt_state = S_HDR;
         end
         S_HDR:
         begin
            if (hdr_take)
            begin
               nxt_cnt = cnt_ff + 5'd1;
               if (cnt_ff == `HDR_LAST)
               begin
                  nxt_state = S_LOOK;
               end
               else if (in_last)
               begin
                  // runt frame: too short to classify
                  nxt_cnt = 5'd0;
                  nxt_drop = 1'b1;
               end
            end
         end
         S_LOOK:
            nxt_state = S_DEC;
         S_DEC:
         begin
            nxt_cnt = 5'd0;
            if (bad_vid || !is_member)
            begin
               nxt_drop = 1'b1;
               nxt_state = last_seen_ff ? S_HDR : S_DROP;
            end
            else
            begin
               nxt_state = S_EMIT;
               if (tagged_ff && is_untag)
                  nxt_mode = M_STRIP;
               else if (!tagged_ff && !is_untag)
                  nxt_mode = M_INS;
               else
                  nxt_mode = M_PASS;
            end
         end
         S_EMIT:
         begin
            buf_push = buf_ready;
            buf_byte = emit_byte;
            if (buf_ready)
            begin
               nxt_cnt = cnt_ff + 5'd1;
               if (cnt_ff == emit_len - 5'd1)
               begin
                  nxt_cnt = 5'd0;
                  nxt_state = last_seen_ff ? S_FCS : S_BODY;
               end
            end
         end
         S_BODY:
         begin
            // in_ready was only raised with a free buffer slot
            buf_push = body_take;
            if (body_take && in_last)
               nxt_state = S_FCS;
         end
         S_FCS:
         begin
            buf_push = buf_ready;
            buf_byte = fcs[{cnt_ff[1:0], 3'b000} +: 8];
            buf_last = (cnt_ff == `FCS_LAST);
            if (buf_ready)
            begin
               nxt_cnt = cnt_ff + 5'd1;
               if (cnt_ff == `FCS_LAST)
               begin
                  nxt_cnt = 5'd0;
                  nxt_state = S_HDR;
               end
            end
         end
         S_DROP:
         begin
            if (in_valid && in_ready_ff && in_last)
               nxt_state = S_HDR;
         end
         default:
            nxt_state = S_HDR;
      endcase
   end

   always @(posedge ref_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         state_ff <= S_INIT;
         cnt_ff <= 5'd0;
         hdr_ff <= 128'h0;
         port_ff <= {`PORT_W{1'b0}};
         egr_ff <= {`PORT_W{1'b0}};
         pri_ff <= 3'h0;
         vid_ff <= `VID_DEFAULT;
         tagged_ff <= 1'b0;
         last_seen_ff <= 1'b0;
         mode_ff <= M_PASS;
         crc_ff <= `CRC_INIT;
         init_addr_ff <= {`TBL_AW{1'b0}};
         in_ready_ff <= 1'b0;
         cfg_ready_ff <= 1'b0;
         cls_valid_ff <= 1'b0;
         cls_vid_ff <= `VID_DEFAULT;
         cls_tagged_ff <= 1'b0;
         drop_ff <= 1'b0;
         // all ports untagged in vlan 1
         v1_member_ff <= {`NPORT{1'b1}};
         v1_untag_ff <= {`NPORT{1'b1}};
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         mode_ff <= nxt_mode;
         drop_ff <= nxt_drop;
         // registered ready looks one cycle ahead at buffer room
         in_ready_ff <= (nxt_state == S_HDR) || (nxt_state == S_DROP) ||
                        ((nxt_state == S_BODY) && (buf_cnt_nxt != 2'd2));
         if (state_ff == S_INIT)
         begin
            init_addr_ff <= init_addr_ff + 12'h001;
            if (init_addr_ff == `TBL_LAST)
               cfg_ready_ff <= 1'b1;
         end
         else if (cfg_vlan_we)
         begin
            if (cfg_vlan_vid == `VID_DEFAULT)
            begin
               v1_member_ff <= cfg_vlan_member;
               v1_untag_ff <= cfg_vlan_untag & cfg_vlan_member;
            end
            else
            begin
               v1_member_ff <= v1_member_ff & ~cfg_vlan_member;
               v1_untag_ff <= v1_untag_ff & ~cfg_vlan_member;
            end
         end
         if (hdr_take)
         begin
            hdr_ff <= {hdr_ff[119:0], in_data};
            last_seen_ff <= in_last;
            if (cnt_ff == 5'd0)
            begin
               port_ff <= in_port;
               egr_ff <= in_egr;
               pri_ff <= in_pri;
            end
         end
         cls_valid_ff <= (state_ff == S_LOOK);
         if (state_ff == S_LOOK)
         begin
            vid_ff <= look_vid;
            tagged_ff <= tag_seen;
            cls_vid_ff <= look_vid;
            cls_tagged_ff <= tag_seen;
         end
         if (state_ff == S_DEC)
            crc_ff <= `CRC_INIT;
         else if (buf_push && state_ff != S_FCS)
            crc_ff <= crc_step(crc_ff, buf_byte);
      end
   end

   byte_skid_buf u_buf (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .push(buf_push),
      .push_data({buf_last, buf_byte}),
      .push_ready(buf_ready),
      .cnt_nxt(buf_cnt_nxt),
      .out_valid(tx_valid),
      .out_data(tx_word),
      .out_ready(tx_ready)
   );

   assign tx_data = tx_word[7:0];
   assign tx_last = tx_word[8];
   assign in_ready = in_ready_ff;
   assign cfg_ready = cfg_ready_ff;
   assign cls_valid = cls_valid_ff;
   assign cls_vid = cls_vid_ff;
   assign cls_tagged = cls_tagged_ff;
   assign drop = drop_ff;
endmodule // vlan_tag_classify_edit

// [verif/vlan_monitor.sv]
// port-level checker for the vlan tag classify and edit block
`timescale 1ns/100ps
`include "vlan_defs.vh"
module vlan_monitor (
   // clock and reset
   input wire ref_clk,
   input wire rst_b,
   // streams
   input wire in_ready,
   input wire tx_valid,
   input wire [7:0] tx_data,
   input wire tx_last,
   input wire tx_ready,
   // status
   input wire cfg_ready,
   input wire cls_valid,
   input wire [`VID_W-1:0] cls_vid,
   input wire cls_tagged,
   input wire drop
);
   logic [12:0] sweep_ff;
   logic [7:0] len_ff;
   // sweep count saturates so a long run cannot wrap it back under the figure
   always @(posedge ref_clk or negedge rst_b)
      if (!rst_b)
      begin
         sweep_ff <= 13'h0000;
         len_ff <= 8'h00;
      end
      else
      begin
         if (sweep_ff != 13'h1fff)
            sweep_ff <= sweep_ff + 13'h0001;
         if (tx_valid && tx_ready)
            len_ff <= tx_last ? 8'h00 : len_ff + 8'h01;
      end
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   sequence stall_s;
      tx_valid && !tx_ready;
   endsequence
   sequence last_taken_s;
      tx_valid && tx_ready && tx_last;
   endsequence
   cfg_hold_a: assert property (cfg_ready |=> cfg_ready)
      else $error("cfg ready fell");
   sweep_len_a: assert property (cfg_ready |-> sweep_ff >= 13'd4096)
      else $error("cfg ready before clear sweep");
   ready_gate_a: assert property (!cfg_ready |-> !in_ready)
      else $error("ingress open before table clear");
   tx_hold_a: assert property (stall_s |=> tx_valid && $stable(tx_data) && $stable(tx_last))
      else $error("egress byte changed while stalled");
   cls_pulse_a: assert property (cls_valid |=> !cls_valid)
      else $error("cls valid longer than one cycle");
   drop_pulse_a: assert property (drop |=> !drop)
      else $error("drop longer than one cycle");
   cls_stand_a: assert property (!cls_valid |-> $stable(cls_vid) && $stable(cls_tagged))
      else $error("cls result moved without cls valid");
   lookup_wait_a: assert property (cls_valid |-> !$past(in_ready))
      else $error("ingress open during lookup");
   frame_len_a: assert property (last_taken_s |-> len_ff >= 8'd15)
      else $error("egress frame shorter than sixteen bytes");
endmodule // vlan_monitor

bind vlan_tag_classify_edit vlan_monitor mon_u (
   .ref_clk(ref_clk), .rst_b(rst_b), .in_ready(in_ready), .tx_valid(tx_valid), .tx_data(tx_data),
   .tx_last(tx_last), .tx_ready(tx_ready), .cfg_ready(cfg_ready), .cls_valid(cls_valid),
   .cls_vid(cls_vid), .cls_tagged(cls_tagged), .drop(drop)
);

// [verif/egress_sink.sv]
// far-side receiver model that takes egress bytes and stalls at random
`timescale 1ns/100ps
module egress_sink (
   // clock and reset
   input wire ref_clk,
   input wire rst_b,
   // egress handshake
   output logic tx_ready,
   // stall control
   input wire stall_en
);
   // a receiver may withdraw ready in any cycle, mid-frame included
   always @(negedge ref_clk or negedge rst_b)
      if (!rst_b)
         tx_ready <= 1'b0;
      else
         tx_ready <= !stall_en || ($urandom % 3 != 0);
endmodule // egress_sink

// [verif/tb.sv]
// self-checking bench for the vlan tag classify and edit block
`timescale 1ns/100ps
`include "vlan_defs.vh"
module tb;
   logic ref_clk, rst_b, in_valid, in_last, cfg_vlan_we, cfg_pvid_we, stall_en;
   logic [7:0] in_data, cfg_vlan_member, cfg_vlan_untag;
   logic [2:0] in_port, in_egr, in_pri, cfg_pvid_port;
   logic [11:0] cfg_vlan_vid, cfg_pvid_vid;
   wire in_ready, tx_valid, tx_last, tx_ready, cfg_ready, cls_valid, cls_tagged, drop;
   wire [7:0] tx_data;
   wire [11:0] cls_vid;
   int errors, comparisons, drops_seen, drops_exp, n;
   logic [8:0] exp_q[$];
   logic [12:0] cls_q[$];
   logic [7:0] fr[$], ob[$];

   vlan_tag_classify_edit dut_u (.ref_clk(ref_clk), .rst_b(rst_b), .in_valid(in_valid), .in_data(in_data),
      .in_last(in_last), .in_port(in_port), .in_egr(in_egr), .in_pri(in_pri), .in_ready(in_ready),
      .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
      .cfg_vlan_we(cfg_vlan_we), .cfg_vlan_vid(cfg_vlan_vid), .cfg_vlan_member(cfg_vlan_member),
      .cfg_vlan_untag(cfg_vlan_untag), .cfg_pvid_we(cfg_pvid_we), .cfg_pvid_port(cfg_pvid_port),
      .cfg_pvid_vid(cfg_pvid_vid), .cfg_ready(cfg_ready), .cls_valid(cls_valid), .cls_vid(cls_vid),
      .cls_tagged(cls_tagged), .drop(drop));
   egress_sink sink_u (.ref_clk(ref_clk), .rst_b(rst_b), .tx_ready(tx_ready), .stall_en(stall_en));

   initial
   begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   task automatic chk_byte(input logic [8:0] got, input logic [8:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t byte got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_cls(input logic [12:0] got, input logic [12:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t cls got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         errors++;
         $display("[FAIL] %0t count got %h exp %h", $time, got, exp);
      end
   endtask

   // watches outputs and takes the oldest note off each queue
   always @(posedge ref_clk)
      if (rst_b)
      begin
         if (tx_valid && tx_ready)
            chk_byte({tx_last, tx_data}, exp_q.size() ? exp_q.pop_front() : 9'h1ff);
         if (cls_valid)
            chk_cls({cls_tagged, cls_vid}, cls_q.size() ? cls_q.pop_front() : 13'h1fff);
         if (drop)
            drops_seen++;
      end

   function automatic logic [31:0] crc_ob();
      logic [31:0] c;
      c = 32'hffffffff;
      foreach (ob[i])
      begin
         c = c ^ {24'h000000, ob[i]};
         repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
      end
      return ~c;
   endfunction

   // mode 0 passes, 1 inserts a tag, 2 strips it, 3 discards
   task automatic run(input int mode, input logic [2:0] port, input logic [2:0] egr, input logic [2:0] pri,
                      input logic [15:0] ety, input logic [15:0] tci, input logic [12:0] cls);
      logic [31:0] f;
      logic [7:0] th;
      fr = {};
      repeat (12) fr.push_back(8'($urandom));
      fr.push_back(ety[15:8]);
      fr.push_back(ety[7:0]);
      fr.push_back(tci[15:8]);
      fr.push_back(tci[7:0]);
      repeat (4 + $urandom % 20) fr.push_back(8'($urandom));
      cls_q.push_back(cls);
      ob = fr;
      // tag control high byte is built packed, so it stays a single octet in the queue
      th = {pri, 1'b0, cls[11:8]};
      if (mode == 1)
         ob = {fr[0:11], 8'h81, 8'h00, th, cls[7:0], fr[12:$]};
      if (mode == 2)
         ob = {fr[0:11], fr[16:$]};
      f = crc_ob();
      ob = {ob, f[7:0], f[15:8], f[23:16], f[31:24]};
      if (mode == 3)
         drops_exp++;
      else
         foreach (ob[i])
            exp_q.push_back({i == ob.size() - 1, ob[i]});
      foreach (fr[i])
      begin
         in_valid = 1'b1;
         in_data = fr[i];
         in_last = (i == fr.size() - 1);
         in_port = port;
         in_egr = egr;
         in_pri = pri;
         while (in_ready !== 1'b1)
            @(negedge ref_clk);
         @(negedge ref_clk);
      end
      in_valid = 1'b0;
      in_last = 1'b0;
      // one idle edge so the next frame never raises valid in the step that lowered it
      @(negedge ref_clk);
   endtask

   task automatic settle(input string name);
      n = 0;
      while ((exp_q.size() + cls_q.size()) != 0 && n < 3000)
      begin
         @(negedge ref_clk);
         n++;
      end
      repeat (4) @(negedge ref_clk);
      chk_cnt(32'(exp_q.size() + cls_q.size()), 32'h0);
      chk_cnt(32'(drops_seen), 32'(drops_exp));
      $display("test %s done", name);
   endtask

   task automatic set_vlan(input logic [11:0] vid, input logic [7:0] mem, input logic [7:0] unt);
      cfg_vlan_vid = vid;
      cfg_vlan_member = mem;
      cfg_vlan_untag = unt;
      cfg_vlan_we = 1'b1;
      @(negedge ref_clk);
      cfg_vlan_we = 1'b0;
      // let an edge pass before a following write raises the strobe again
      @(negedge ref_clk);
   endtask

   task automatic end_sim();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   initial
   begin
      repeat (30000) @(posedge ref_clk);
      errors++;
      end_sim();
   end

   initial
   begin
      {rst_b, in_valid, in_last, cfg_vlan_we, cfg_pvid_we, stall_en} = 6'h00;
      {in_data, in_port, in_egr, in_pri, cfg_pvid_port} = 20'h00000;
      {cfg_vlan_vid, cfg_pvid_vid, cfg_vlan_member, cfg_vlan_untag} = 40'h0;
      void'($urandom(32'hd3c0d0f0));
      repeat (8) @(negedge ref_clk);
      rst_b = 1'b1;
      n = 0;
      while (cfg_ready !== 1'b1 && n < 6000)
      begin
         @(negedge ref_clk);
         n++;
      end
      run(0, 3'd3, 3'd5, 3'd2, 16'h0800, 16'h0000, 13'h0001);
      run(2, 3'd2, 3'd4, 3'd0, 16'h8100, 16'ha001, 13'h1001);
      run(0, 3'd1, 3'd6, 3'd0, 16'h8101, 16'h0000, 13'h0001);
      settle("defaults");
      stall_en = 1'b1;
      set_vlan(12'h00a, 8'h03, 8'h01);
      set_vlan(12'hffe, 8'h22, 8'h00);
      cfg_pvid_port = 3'd0;
      cfg_pvid_vid = 12'h00a;
      cfg_pvid_we = 1'b1;
      @(negedge ref_clk);
      cfg_pvid_we = 1'b0;
      run(1, 3'd0, 3'd1, 3'd6, 16'h0800, 16'h0000, 13'h000a);
      run(3, 3'd0, 3'd2, 3'd6, 16'h0800, 16'h0000, 13'h000a);
      run(3, 3'd3, 3'd0, 3'd0, 16'h8100, 16'h0001, 13'h1001);
      run(0, 3'd5, 3'd1, 3'd0, 16'h8100, 16'h600a, 13'h100a);
      run(2, 3'd5, 3'd0, 3'd0, 16'h8100, 16'h600a, 13'h100a);
      run(0, 3'd4, 3'd1, 3'd0, 16'h8100, 16'h2ffe, 13'h1ffe);
      run(3, 3'd4, 3'd1, 3'd0, 16'h8100, 16'h2000, 13'h1000);
      run(3, 3'd4, 3'd1, 3'd0, 16'h8100, 16'h2fff, 13'h1fff);
      settle("vlans");
      end_sim();
   end
endmodule // tb
